// >>> led_frame_memory_and_control_map_bench.sv
module led_frame_memory_and_control_map_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wr_en, rd_en, rd_valid, mcs, frame_active, movie_running, blink, b0;
    logic [3:0] page_sel;
    logic [2:0] shown_frame;
    logic [7:0] reg_addr, wr_data, rd_data, disp_opt, scan_byte, got;
    logic [7:0] fault_in = 8'h3c;
    logic [7:0] state_in = 8'hc3;
    logic [7:0] scan_addr = 8'h00;
    logic [7:0] rst_tab [15] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h1e, 8'h00, 8'h00, 8'hff, 8'h3c, 8'hc3, 8'h00};
    // page, address, write data, expected read back
    logic [31:0] ft [10] = '{32'h0001ff7f, 32'h001dff7f, 32'h0012ffff, 32'h00b2a5a5,
        32'h00240101, 32'h00b35a00, 32'h000c5a00, 32'h00235a00, 32'h01005555, 32'h0000aaaa};
    int errors = 0;
    int edges;
    int check_count = 0;
    always #4 sys_clk = ~sys_clk;
    lfm_top #(.DWELL_STEP_CYC(10), .BLINK_HALF_CYC(8)) lfm_top_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1), .wr_en(wr_en), .rd_en(rd_en),
        .page_sel(page_sel), .reg_addr(reg_addr), .wr_data(wr_data),
        .fault_result_in(fault_in), .device_state_in(state_in), .rd_data(rd_data),
        .rd_valid(rd_valid), .matrix_count_select_bit(mcs), .disp_opt(disp_opt),
        .shown_frame(shown_frame), .frame_active(frame_active), .movie_running(movie_running),
        .blink_phase(blink), .scan_byte(scan_byte), .scan_addr(scan_addr)
    );
    lfm_host lfm_host_i (
        .sys_clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data), .wr_en(wr_en),
        .rd_en(rd_en), .page_sel(page_sel), .reg_addr(reg_addr), .wr_data(wr_data)
    );
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] exp);
        lfm_host_i.get(page, addr, got);
        check($sformatf("page %0d addr %h", page, addr), got, exp);
    endtask
    task automatic show(input logic [7:0] fs, input int wait_cyc);
        lfm_host_i.put(4'h6, 8'h00, fs);
        repeat (wait_cyc) @(negedge sys_clk);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // reads are not answered until the frame clear sweep is over
        repeat (1080) @(posedge sys_clk);
        for (int i = 0; i < 15; i++) rd_chk(4'h6, 8'(i), rst_tab[i]);
        rd_chk(4'h0, 8'h0a, 8'h00);
        for (int i = 0; i < 10; i++) begin
            lfm_host_i.put(ft[i][27:24], ft[i][23:16], ft[i][15:8]);
            rd_chk(ft[i][27:24], ft[i][23:16], ft[i][7:0]);
        end
        rd_chk(4'h1, 8'h00, 8'h55);
        lfm_host_i.put(4'h6, 8'h0c, 8'h00);
        rd_chk(4'h6, 8'h0c, 8'h3c);
        lfm_host_i.put(4'h6, 8'h04, 8'h01);
        @(negedge sys_clk);
        check("matrix count bit", {7'h00, mcs}, 8'h01);
        lfm_host_i.put(4'h6, 8'h04, 8'h00);
        lfm_host_i.put(4'h6, 8'h03, 8'h17);
        @(negedge sys_clk);
        check("display options", disp_opt, 8'h17);
        // long blink period bit set: time between two toggles is twice the base of 8
        b0 = blink;
        edges = 0;
        got = 8'h00;
        for (int n = 0; n < 64; n++) begin
            @(negedge sys_clk);
            if (got == 8'h01) edges++;
            if (blink !== b0) begin
                b0 = blink;
                got = got + 8'h01;
            end
        end
        check("blink half period", 8'(edges), 8'h10);
        show(8'h41, 5);
        check("still active", {7'h00, frame_active}, 8'h01);
        check("still frame", {5'h00, shown_frame}, 8'h01);
        check("scan byte", scan_byte, 8'h55);
        show(8'h46, 3);
        check("invalid still", {7'h00, frame_active}, 8'h00);
        lfm_host_i.put(4'h6, 8'h01, 8'h00);
        lfm_host_i.put(4'h6, 8'h02, 8'h01);
        show(8'hd1, 3);
        check("movie running", {7'h00, movie_running}, 8'h01);
        check("movie start", {5'h00, shown_frame}, 8'h02);
        for (int n = 0; movie_running !== 1'b0; n++) begin
            if (n == 200) begin
                errors++;
                finish_test();
            end
            @(negedge sys_clk);
        end
        check("still after movie", {4'h0, frame_active, shown_frame}, 8'h09);
        show(8'h00, 3);
        check("nothing shown", {7'h00, frame_active}, 8'h00);
        finish_test();
    end
endmodule

// >>> lfm_frame_ram.sv
module lfm_frame_ram #(
    parameter int DEPTH = 1080
) (
    input wire logic sys_clk, // clock
    input wire logic clk_en, // freeze when low
    lfm_mem_if.store mem // write and read port
);
    logic [7:0] ram_q [DEPTH];
    logic [7:0] rd_q;

    initial begin
        if (DEPTH < 1 || DEPTH > 2048) $error("frame ram depth out of range");
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && mem.we && int'(mem.waddr) < DEPTH) begin
            ram_q[mem.waddr] <= mem.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            rd_q <= (int'(mem.raddr) < DEPTH) ? ram_q[mem.raddr] : 8'h00;
        end
    end

    assign mem.rdata = rd_q;
endmodule

// >>> lfm_host.sv
module lfm_host (
    input wire logic sys_clk, // clock
    input wire logic rd_valid, // read valid
    input wire logic [7:0] rd_data, // read data
    output logic wr_en, // write strobe
    output logic rd_en, // read strobe
    output logic [3:0] page_sel, // page
    output logic [7:0] reg_addr, // address
    output logic [7:0] wr_data // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        page_sel = 4'h6;
        reg_addr = 8'h00;
        wr_data = 8'h00;
    end
    task automatic put(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        wr_en <= 1'b1;
        page_sel <= page;
        reg_addr <= addr;
        wr_data <= data;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        wr_data <= ~data;
    endtask
    task automatic get(input logic [3:0] page, input logic [7:0] addr, output logic [7:0] data);
        data = 8'hxx;
        @(posedge sys_clk);
        rd_en <= 1'b1;
        page_sel <= page;
        reg_addr <= addr;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            @(negedge sys_clk);
            if (rd_valid === 1'b1) begin
                data = rd_data;
                break;
            end
        end
    endtask
endmodule

// >>> lfm_mem_if.sv
interface lfm_mem_if;
    logic we;
    logic [10:0] waddr;
    logic [7:0] wdata;
    logic [10:0] raddr;
    logic [7:0] rdata;
    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> lfm_pkg.sv
package lfm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FRAMES = 6;
    localparam int FRAME_BYTES = 180;
    localparam logic [7:0] ONOFF_FIRST = 8'h00;
    localparam logic [7:0] ONOFF_LAST = 8'h0b;
    localparam logic [7:0] BLINK_FIRST = 8'h12;
    localparam logic [7:0] BLINK_LAST = 8'h1d;
    localparam logic [7:0] INTENS_FIRST = 8'h24;
    localparam logic [7:0] INTENS_LAST = 8'hb2;
    localparam int ODD_UNUSED_BIT = 7;
    localparam logic [7:0] OFS_FRAME_SELECT = 8'h00;
    localparam logic [7:0] OFS_MOVIE_PLAYBACK_SETUP = 8'h01;
    localparam logic [7:0] OFS_FRAME_DWELL_TIME = 8'h02;
    localparam logic [7:0] OFS_DISPLAY_OPTIONS = 8'h03;
    localparam logic [7:0] OFS_DEVICE_CONFIGURATION = 8'h04;
    localparam logic [7:0] OFS_MATRIX_A_CURRENT = 8'h05;
    localparam logic [7:0] OFS_MATRIX_B_CURRENT = 8'h06;
    localparam logic [7:0] OFS_MATRIX_C_CURRENT = 8'h07;
    localparam logic [7:0] OFS_PUMP_CONFIGURATION = 8'h08;
    localparam logic [7:0] OFS_LED_FAULT_TEST_CONTROL = 8'h09;
    localparam logic [7:0] OFS_POWER_DOWN_CONTROL = 8'h0a;
    localparam logic [7:0] OFS_BUS_WATCHDOG_SETUP = 8'h0b;
    localparam logic [7:0] OFS_LED_FAULT_RESULT = 8'h0c;
    localparam logic [7:0] OFS_DEVICE_STATE = 8'h0d;
    localparam logic [7:0] RST_FRAME_SELECT = 8'h00;
    localparam logic [7:0] RST_MOVIE_PLAYBACK_SETUP = 8'h00;
    localparam logic [7:0] RST_FRAME_DWELL_TIME = 8'h00;
    localparam logic [7:0] RST_DISPLAY_OPTIONS = 8'h07;
    localparam logic [7:0] RST_DEVICE_CONFIGURATION = 8'h00;
    localparam logic [7:0] RST_CURRENT = 8'h00;
    localparam logic [7:0] RST_PUMP_CONFIGURATION = 8'h1e;
    localparam logic [7:0] RST_LED_FAULT_TEST_CONTROL = 8'h00;
    localparam logic [7:0] RST_POWER_DOWN_CONTROL = 8'h00;
    localparam logic [7:0] RST_BUS_WATCHDOG_SETUP = 8'hff;
    localparam int FS_MOVIE_BIT = 7;
    localparam int FS_PICTURE_BIT = 6;
    localparam int FS_START_HI = 5;
    localparam int FS_START_LO = 3;
    localparam int FS_STILL_HI = 2;
    localparam int FS_STILL_LO = 0;
    localparam logic [2:0] LAST_FRAME_CODE = 3'h5;
    localparam int CFG_MATRIX_COUNT_SELECT_BIT = 0;
    localparam int DO_BLINK_PERIOD_BIT = 4;
    localparam int DO_BLINK_START_BIT = 5;
    localparam int PLAY_LOOPS_HI = 5;
    localparam int PLAY_LOOPS_LO = 3;
    localparam int PLAY_FRAMES_HI = 2;
    localparam int PLAY_FRAMES_LO = 0;
    localparam logic [2:0] LOOPS_ENDLESS = 3'h7;
    localparam int CLK_HZ = 125_000_000;
    localparam int DWELL_STEP_US = 32500;
    localparam int DWELL_STEP_CYC = CLK_HZ / 1_000_000 * DWELL_STEP_US;
    localparam int BLINK_SHORT_MS = 1500;
    localparam int BLINK_SHORT_CYC = CLK_HZ / 1000 * BLINK_SHORT_MS / 2;
    typedef enum logic [1:0] {
        LFM_IDLE = 2'b00,
        LFM_MOVIE = 2'b01,
        LFM_STILL = 2'b11
    } lfm_state_t;
endpackage

// >>> lfm_top.sv
// Operation
// RULE_01: configuration bit zero picks two or three matrices, each on its own line group.
// RULE_02: frame on/off bits reset dark; a one lights the led.
// RULE_03: on/off bytes 0x00..0x0b in even/odd pairs; odd byte bit seven unused.
// RULE_04: each pair serves lines n, n+6, n+12 for n from 0 to 5.
// RULE_05: every led has its own blink enable bit.
// RULE_06: blink period comes from display options register at 0x03.
// RULE_07: blink bytes 0x12..0x1d, same pairing and bit order, bit seven unused.
// RULE_08: each led has an 8-bit pwm intensity byte.
// RULE_09: intensity bytes run 0x24 to 0xb2, one per led, grouped by line.
// RULE_10: led numbering starts at the first line of each matrix.
// RULE_11: control registers selected by an 8-bit address, fourteen registers counted.
// RULE_12: host selects the control page before addressing control registers.
// RULE_13: control page decodes 0x00..0x0d in the listed order.
// RULE_14: frame select resets to 0x00: nothing shown, both pointers frame 0.
// RULE_15: host programs frame select for still picture or movie and start frame.
// RULE_16: frame select bit seven starts movie playback.
// RULE_17: frame select bit six enables the still picture.
// RULE_18: frame select bits 5:3 give the movie start frame 0..5.
// RULE_19: frame select bits 2:0 give the still frame 0..5.
// RULE_20: with both bits set, play the movie then show the still picture.
// RULE_21: frame layout is identical for every frame; only the page differs.
// RULE_22: configuration bit zero: 0 three 5x6 matrices, 1 two 8x9; resets 0.
// RULE_23: frame codes 110 and 111 select no stored frame.
module lfm_top #(
    parameter int FRAMES = lfm_pkg::FRAMES,
    parameter int DWELL_STEP_CYC = lfm_pkg::DWELL_STEP_CYC,
    parameter int BLINK_HALF_CYC = lfm_pkg::BLINK_SHORT_CYC
) (
    input wire logic sys_clk, // 125 MHz clock
    input wire logic sys_rst, // async reset, active high
    input wire logic clk_en, // freezes all state while low
    input wire logic wr_en, // one-cycle register write strobe
    input wire logic rd_en, // one-cycle register read strobe
    input wire logic [3:0] page_sel, // 0..5 frame page, other values control page
    input wire logic [7:0] reg_addr, // register address within page
    input wire logic [7:0] wr_data, // write data
    input wire logic [7:0] fault_result_in, // led fault result from analog side
    input wire logic [7:0] device_state_in, // device state from analog side
    output logic [7:0] rd_data, // read data, registered
    output logic rd_valid, // read data valid pulse
    output logic matrix_count_select_bit, // 0 three matrices, 1 two matrices
    output logic [7:0] disp_opt, // display options register
    output logic [2:0] shown_frame, // frame currently on display
    output logic frame_active, // a frame is being displayed
    output logic movie_running, // movie playback in progress
    output logic blink_phase, // blinking leds are lit while high
    output logic [7:0] scan_byte, // frame byte at scan address, registered
    input wire logic [7:0] scan_addr // byte offset within displayed frame
);
    initial begin
        if (FRAMES < 1 || FRAMES > 6) $error("frame count must be 1..6");
        if (DWELL_STEP_CYC < 1 || BLINK_HALF_CYC < 1) $error("counts must be positive");
    end

    lfm_mem_if mem ();
    lfm_frame_ram #(.DEPTH(FRAMES * lfm_pkg::FRAME_BYTES)) u_ram (
        .sys_clk(sys_clk),
        .clk_en(clk_en),
        .mem(mem)
    );

    // layout is the same in every frame; only the page base moves
    function automatic logic [10:0] frame_base(input logic [2:0] f);
        return 11'(int'(f) * lfm_pkg::FRAME_BYTES); // RULE_21
    endfunction

    function automatic logic frame_ok(input logic [2:0] f);
        return (f <= lfm_pkg::LAST_FRAME_CODE) && (int'(f) < FRAMES); // RULE_23
    endfunction

    // writable byte within a frame, and mask dropping the unused odd-byte bit
    function automatic logic [7:0] byte_mask(input logic [7:0] a);
        logic [7:0] m;
        m = 8'h00;
        if (a >= lfm_pkg::ONOFF_FIRST && a <= lfm_pkg::ONOFF_LAST) begin // RULE_03 RULE_04
            m = a[0] ? 8'h7f : 8'hff;
        end else if (a >= lfm_pkg::BLINK_FIRST && a <= lfm_pkg::BLINK_LAST) begin // RULE_05 RULE_07
            m = a[0] ? 8'h7f : 8'hff;
        end else if (a >= lfm_pkg::INTENS_FIRST && a <= lfm_pkg::INTENS_LAST) begin // RULE_08 RULE_09
            m = 8'hff;
        end
        return m;
    endfunction

    logic [7:0] frame_select_q;
    logic [7:0] play_setup_q;
    logic [7:0] dwell_q;
    logic [7:0] disp_opt_q;
    logic [7:0] config_q;
    logic [7:0] cur_a_q;
    logic [7:0] cur_b_q;
    logic [7:0] cur_c_q;
    logic [7:0] pump_q;
    logic [7:0] fault_test_q;
    logic [7:0] power_q;
    logic [7:0] watchdog_q;

    logic ctrl_page;
    logic [2:0] page_frame;
    logic [7:0] wmask;
    logic frame_wr;
    logic frame_rd;
    assign ctrl_page = page_sel > 4'h5; // RULE_12
    assign page_frame = page_sel[2:0];
    assign wmask = byte_mask(reg_addr);
    assign frame_wr = wr_en && !ctrl_page && frame_ok(page_frame) && wmask != 8'h00;
    assign frame_rd = rd_en && !ctrl_page && frame_ok(page_frame) && wmask != 8'h00;

    // control page register writes
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_select_q <= lfm_pkg::RST_FRAME_SELECT; // RULE_14
            play_setup_q <= lfm_pkg::RST_MOVIE_PLAYBACK_SETUP;
            dwell_q <= lfm_pkg::RST_FRAME_DWELL_TIME;
            disp_opt_q <= lfm_pkg::RST_DISPLAY_OPTIONS;
            config_q <= lfm_pkg::RST_DEVICE_CONFIGURATION; // RULE_22
            cur_a_q <= lfm_pkg::RST_CURRENT;
            cur_b_q <= lfm_pkg::RST_CURRENT;
            cur_c_q <= lfm_pkg::RST_CURRENT;
            pump_q <= lfm_pkg::RST_PUMP_CONFIGURATION;
            fault_test_q <= lfm_pkg::RST_LED_FAULT_TEST_CONTROL;
            power_q <= lfm_pkg::RST_POWER_DOWN_CONTROL;
            watchdog_q <= lfm_pkg::RST_BUS_WATCHDOG_SETUP;
        end else if (clk_en && wr_en && ctrl_page) begin
            case (reg_addr) // RULE_11 RULE_13
                lfm_pkg::OFS_FRAME_SELECT: frame_select_q <= wr_data; // RULE_15
                lfm_pkg::OFS_MOVIE_PLAYBACK_SETUP: play_setup_q <= {2'b00, wr_data[5:0]};
                lfm_pkg::OFS_FRAME_DWELL_TIME: dwell_q <= {4'h0, wr_data[3:0]};
                lfm_pkg::OFS_DISPLAY_OPTIONS: disp_opt_q <= {1'b0, wr_data[6:0]};
                lfm_pkg::OFS_DEVICE_CONFIGURATION: config_q <= {5'h00, wr_data[2:0]}; // RULE_01
                lfm_pkg::OFS_MATRIX_A_CURRENT: cur_a_q <= wr_data;
                lfm_pkg::OFS_MATRIX_B_CURRENT: cur_b_q <= wr_data;
                lfm_pkg::OFS_MATRIX_C_CURRENT: cur_c_q <= wr_data;
                lfm_pkg::OFS_PUMP_CONFIGURATION: pump_q <= {3'h0, wr_data[4:0]};
                lfm_pkg::OFS_LED_FAULT_TEST_CONTROL: fault_test_q <= {6'h00, wr_data[1:0]};
                lfm_pkg::OFS_POWER_DOWN_CONTROL: power_q <= {7'h00, wr_data[0]};
                lfm_pkg::OFS_BUS_WATCHDOG_SETUP: watchdog_q <= wr_data;
                default: ;
            endcase
        end
    end

    // register read mux
    logic [7:0] ctrl_rd;
    always_comb begin
        case (reg_addr) // RULE_13
            lfm_pkg::OFS_FRAME_SELECT: ctrl_rd = frame_select_q;
            lfm_pkg::OFS_MOVIE_PLAYBACK_SETUP: ctrl_rd = play_setup_q;
            lfm_pkg::OFS_FRAME_DWELL_TIME: ctrl_rd = dwell_q;
            lfm_pkg::OFS_DISPLAY_OPTIONS: ctrl_rd = disp_opt_q;
            lfm_pkg::OFS_DEVICE_CONFIGURATION: ctrl_rd = config_q;
            lfm_pkg::OFS_MATRIX_A_CURRENT: ctrl_rd = cur_a_q;
            lfm_pkg::OFS_MATRIX_B_CURRENT: ctrl_rd = cur_b_q;
            lfm_pkg::OFS_MATRIX_C_CURRENT: ctrl_rd = cur_c_q;
            lfm_pkg::OFS_PUMP_CONFIGURATION: ctrl_rd = pump_q;
            lfm_pkg::OFS_LED_FAULT_TEST_CONTROL: ctrl_rd = fault_test_q;
            lfm_pkg::OFS_POWER_DOWN_CONTROL: ctrl_rd = power_q;
            lfm_pkg::OFS_BUS_WATCHDOG_SETUP: ctrl_rd = watchdog_q;
            lfm_pkg::OFS_LED_FAULT_RESULT: ctrl_rd = fault_result_in;
            lfm_pkg::OFS_DEVICE_STATE: ctrl_rd = device_state_in;
            default: ctrl_rd = 8'h00;
        endcase
    end

    // frame memory clear sweep after reset: every byte starts dark
    logic clearing_q;
    logic [10:0] clr_addr_q;
    localparam int MEM_LAST = FRAMES * lfm_pkg::FRAME_BYTES - 1;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clearing_q <= 1'b1;
            clr_addr_q <= 11'h000;
        end else if (clk_en && clearing_q) begin
            if (clr_addr_q == 11'(MEM_LAST)) begin
                clearing_q <= 1'b0;
            end
            clr_addr_q <= clr_addr_q + 11'h001;
        end
    end

    // playback sequencer
    lfm_pkg::lfm_state_t state_q;
    logic [2:0] cur_frame_q;
    logic [2:0] frames_done_q;
    logic [2:0] loops_done_q;
    logic [31:0] dwell_cnt_q;
    logic fs_wr_q;
    logic [2:0] start_f;
    logic [2:0] still_f;
    logic [2:0] n_frames;
    logic [2:0] n_loops;
    logic movie_bit;
    logic pic_bit;
    logic fs_written;
    logic [31:0] dwell_target;
    assign movie_bit = frame_select_q[lfm_pkg::FS_MOVIE_BIT]; // RULE_16
    assign pic_bit = frame_select_q[lfm_pkg::FS_PICTURE_BIT]; // RULE_17
    assign start_f = frame_select_q[lfm_pkg::FS_START_HI:lfm_pkg::FS_START_LO]; // RULE_18
    assign still_f = frame_select_q[lfm_pkg::FS_STILL_HI:lfm_pkg::FS_STILL_LO]; // RULE_19
    assign n_frames = play_setup_q[lfm_pkg::PLAY_FRAMES_HI:lfm_pkg::PLAY_FRAMES_LO];
    assign n_loops = play_setup_q[lfm_pkg::PLAY_LOOPS_HI:lfm_pkg::PLAY_LOOPS_LO];
    assign fs_written = fs_wr_q;
    assign dwell_target = 32'(int'(dwell_q[3:0]) * DWELL_STEP_CYC);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= lfm_pkg::LFM_IDLE;
            cur_frame_q <= 3'h0;
            frames_done_q <= 3'h0;
            loops_done_q <= 3'h0;
            dwell_cnt_q <= 32'h0;
            fs_wr_q <= 1'b0;
        end else if (clk_en) begin
            fs_wr_q <= wr_en && ctrl_page && reg_addr == lfm_pkg::OFS_FRAME_SELECT;
            if (fs_written) begin
                frames_done_q <= 3'h0;
                loops_done_q <= 3'h0;
                dwell_cnt_q <= 32'h0;
                if (movie_bit && frame_ok(start_f)) begin
                    state_q <= lfm_pkg::LFM_MOVIE;
                    cur_frame_q <= start_f;
                end else if (pic_bit && frame_ok(still_f)) begin
                    state_q <= lfm_pkg::LFM_STILL;
                    cur_frame_q <= still_f;
                end else begin
                    state_q <= lfm_pkg::LFM_IDLE; // RULE_23
                end
            end else begin
                case (state_q)
                    lfm_pkg::LFM_MOVIE: begin
                        if (dwell_cnt_q + 32'h1 < dwell_target) begin
                            dwell_cnt_q <= dwell_cnt_q + 32'h1;
                        end else begin
                            dwell_cnt_q <= 32'h0;
                            if (frames_done_q < n_frames) begin
                                frames_done_q <= frames_done_q + 3'h1;
                                cur_frame_q <= (cur_frame_q == 3'(FRAMES - 1)) ? 3'h0
                                    : cur_frame_q + 3'h1;
                            end else if (n_loops == lfm_pkg::LOOPS_ENDLESS
                                    || loops_done_q < n_loops) begin
                                frames_done_q <= 3'h0;
                                cur_frame_q <= start_f;
                                if (n_loops != lfm_pkg::LOOPS_ENDLESS) begin
                                    loops_done_q <= loops_done_q + 3'h1;
                                end
                            end else if (pic_bit && frame_ok(still_f)) begin
                                state_q <= lfm_pkg::LFM_STILL; // RULE_20
                                cur_frame_q <= still_f;
                            end else begin
                                state_q <= lfm_pkg::LFM_IDLE;
                            end
                        end
                    end
                    lfm_pkg::LFM_STILL: ;
                    lfm_pkg::LFM_IDLE: ;
                    default: state_q <= lfm_pkg::LFM_IDLE;
                endcase
            end
        end
    end

    // blink timebase, period taken from the display options register
    logic [31:0] blink_cnt_q;
    logic blink_q;
    logic [31:0] blink_half;
    assign blink_half = disp_opt_q[lfm_pkg::DO_BLINK_PERIOD_BIT]
        ? 32'(2 * BLINK_HALF_CYC) : 32'(BLINK_HALF_CYC); // RULE_06
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            blink_cnt_q <= 32'h0;
            blink_q <= 1'b1;
        end else if (clk_en) begin
            if (blink_cnt_q + 32'h1 >= blink_half) begin
                blink_cnt_q <= 32'h0;
                blink_q <= !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h1;
            end
        end
    end

    // memory port: clear sweep first, then bus writes; reads share with scan
    logic rd_pend_q;
    logic ctrl_rd_pend_q;
    logic [7:0] ctrl_rd_q;
    always_comb begin
        mem.we = clearing_q || frame_wr;
        mem.waddr = clearing_q ? clr_addr_q : frame_base(page_frame) + 11'(reg_addr);
        mem.wdata = clearing_q ? 8'h00 : (wr_data & wmask); // RULE_02 RULE_03 RULE_07
        mem.raddr = frame_rd ? frame_base(page_frame) + 11'(reg_addr)
            : frame_base(cur_frame_q) + 11'(scan_addr); // RULE_10
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend_q <= 1'b0;
            ctrl_rd_pend_q <= 1'b0;
            ctrl_rd_q <= 8'h00;
        end else if (clk_en) begin
            rd_pend_q <= rd_en && !clearing_q;
            ctrl_rd_pend_q <= rd_en && !frame_rd;
            ctrl_rd_q <= ctrl_page ? ctrl_rd : 8'h00;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            scan_byte <= 8'h00;
        end else if (clk_en) begin
            rd_valid <= rd_pend_q;
            if (rd_pend_q) begin
                rd_data <= ctrl_rd_pend_q ? ctrl_rd_q : mem.rdata;
            end else if (state_q != lfm_pkg::LFM_IDLE) begin
                scan_byte <= mem.rdata;
            end
        end
    end

    assign matrix_count_select_bit = config_q[lfm_pkg::CFG_MATRIX_COUNT_SELECT_BIT]; // RULE_22
    assign disp_opt = disp_opt_q;
    assign shown_frame = cur_frame_q;
    assign frame_active = state_q != lfm_pkg::LFM_IDLE;
    assign movie_running = state_q == lfm_pkg::LFM_MOVIE;
    assign blink_phase = blink_q;
endmodule

// >>> lfm_top_properties.sv
module lfm_checker #(
    parameter int FRAMES = 6
) (
    input wire logic sys_clk, // clock
    input wire logic sys_rst, // reset
    input wire logic clk_en, // enable
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    input wire logic [3:0] page_sel, // page
    input wire logic [7:0] reg_addr, // address
    input wire logic [7:0] wr_data, // write data
    input wire logic rd_valid, // read valid
    input wire logic matrix_count_select_bit, // matrix count
    input wire logic [7:0] disp_opt, // display options
    input wire logic [2:0] shown_frame, // shown frame
    input wire logic frame_active, // frame shown
    input wire logic movie_running // movie on
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic ctl_wr;
    logic fs_wr;
    assign ctl_wr = clk_en && wr_en && page_sel > 4'h5;
    assign fs_wr = ctl_wr && reg_addr == 8'h00;
    // read answers are held off while the frame memory clear sweep runs
    localparam int SWEEP_CYC = FRAMES * lfm_pkg::FRAME_BYTES;
    int sweep_cnt;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sweep_cnt <= 0;
        end else if (clk_en && sweep_cnt < SWEEP_CYC) begin
            sweep_cnt <= sweep_cnt + 1;
        end
    end
    a_read_latency: assert property (
        clk_en && rd_en && page_sel > 4'h5 && sweep_cnt >= SWEEP_CYC |-> ##2 rd_valid)
        else $error("read answer missing");
    a_valid_cause: assert property (rd_valid |-> $past(rd_en, 2))
        else $error("read valid without request");
    a_still_shown: assert property (
        fs_wr && wr_data[7:6] == 2'b01 && wr_data[2:0] < FRAMES
        |-> ##2 frame_active && shown_frame == $past(wr_data[2:0], 2))
        else $error("still frame not shown");
    a_bad_still: assert property (
        fs_wr && wr_data[7:6] == 2'b01 && wr_data[2:0] >= FRAMES |-> ##2 !frame_active)
        else $error("invalid still code shown");
    a_movie_start: assert property (
        fs_wr && wr_data[7] && wr_data[5:3] < FRAMES
        |-> ##2 movie_running && shown_frame == $past(wr_data[5:3], 2))
        else $error("movie did not start at start frame");
    a_nothing_shown: assert property (fs_wr && wr_data[7:6] == 2'b00 |-> ##2 !frame_active)
        else $error("frame shown with both bits clear");
    a_cfg_follow: assert property (
        ctl_wr && reg_addr == 8'h04 |=> matrix_count_select_bit == $past(wr_data[0]))
        else $error("matrix count bit not updated");
    a_blink_source: assert property (
        ctl_wr && reg_addr == 8'h03 |=> disp_opt[6:0] == $past(wr_data[6:0]))
        else $error("display options not updated");
    a_reset_values: assert property (
        $fell(sys_rst) |-> !frame_active && disp_opt == 8'h07 && !matrix_count_select_bit)
        else $error("wrong values after reset");
endmodule

bind lfm_top lfm_checker #(.FRAMES(FRAMES)) lfm_checker_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en),
    .page_sel(page_sel), .reg_addr(reg_addr), .wr_data(wr_data), .rd_valid(rd_valid),
    .matrix_count_select_bit(matrix_count_select_bit), .disp_opt(disp_opt),
    .shown_frame(shown_frame), .frame_active(frame_active), .movie_running(movie_running)
);
